/* File: hdl/esp_front.sv */
// Select, clock-edge and write-protect front end of a serial EEPROM.
// Assumes the serial pins arrive asynchronously and a command core sits behind.
`timescale 1ns/100ps
`include "esp_regs.svh"

module esp_front #(
  parameter int TWC_CYCLES = `ESP_TWC_MS * `ESP_CLK_KHZ // Write cycle length, clocks
) (
  input  wire logic                      i_clk,                // System clock
  input  wire logic                      i_rst,                // Async reset, active high
  input  wire logic                      i_ce,                 // Clock enable, freezes state
  input  wire logic                      i_cs_n,               // Chip select pin, active low
  input  wire logic                      i_sck,                // Serial clock pin
  input  wire logic                      i_si,                 // Serial data input pin
  input  wire logic                      i_hold_n,             // Pause pin, active low
  input  wire logic                      i_wp_n,               // Write-protect pin, active low
  output logic                           o_so,                 // Serial data output
  output logic                           o_so_oe,              // Output enable for serial data
  output esp_pkg::esp_rx_t               o_rx,                 // Received byte
  output logic                           o_rx_valid,           // Received byte present
  input  wire logic                      i_rx_ready,           // Core takes received byte
  output logic                           o_rx_overrun,         // Byte lost, FIFO full
  input  wire logic [`ESP_BYTE_BITS-1:0] i_tx_data,            // Next byte to shift out
  output logic                           o_tx_take,            // Pulse: tx byte loaded
  input  wire logic                      i_write_ok,           // Core: a write sequence is armed
  input  wire logic                      i_sr_write,           // Core: armed write targets status
  input  wire logic                      i_protect_pin_enable, // Status enable bit for protect pin
  output logic                           o_write_start,        // Pulse: internal write begins
  output logic                           o_write_busy,         // Internal write in progress
  output logic                           o_sr_blocked,         // Pulse: status write refused
  output logic                           o_frame_abort,        // Pulse: sequence abandoned
  output logic                           o_standby             // Device in standby
);
  import esp_pkg::*;

  localparam int TW = $clog2(TWC_CYCLES + 1);

  // Elaboration check: a zero-length write cycle cannot be counted
  if (TWC_CYCLES < 1) begin : g_param_check
    $error("esp_front: TWC_CYCLES must be at least 1");
  end

  // Pin synchronisers; only the second stage is read by logic
  logic [1:0] cs_sync_ff;
  logic [1:0] sck_sync_ff;
  logic [1:0] si_sync_ff;
  logic [1:0] hold_sync_ff;
  logic [1:0] wp_sync_ff;
  logic       sck_prev_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync_ff   <= `ESP_PIN_IDLE;
      sck_sync_ff  <= '0;
      si_sync_ff   <= '0;
      hold_sync_ff <= `ESP_PIN_IDLE;
      wp_sync_ff   <= `ESP_PIN_IDLE;
      sck_prev_ff  <= 1'b0;
    end else if (i_ce) begin
      cs_sync_ff   <= {cs_sync_ff[0], i_cs_n};
      sck_sync_ff  <= {sck_sync_ff[0], i_sck};
      si_sync_ff   <= {si_sync_ff[0], i_si};
      hold_sync_ff <= {hold_sync_ff[0], i_hold_n};
      wp_sync_ff   <= {wp_sync_ff[0], i_wp_n};
      sck_prev_ff  <= sck_sync_ff[1];
    end
  end

  logic cs_n;
  logic hold_n;
  logic wp_n;
  logic sck_rise;
  logic sck_fall;

  assign cs_n     = cs_sync_ff[1];
  assign hold_n   = hold_sync_ff[1];
  assign wp_n     = wp_sync_ff[1];
  assign sck_rise = sck_sync_ff[1] && !sck_prev_ff;
  assign sck_fall = !sck_sync_ff[1] && sck_prev_ff;

  // Frame tracking; a frame only opens on a select low level seen after reset
  logic frame_ff;
  logic frame_end;
  logic shift_en;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_ff <= 1'b0;
    end else if (i_ce) begin
      frame_ff <= !cs_n;
    end
  end

  assign frame_end = frame_ff && cs_n;
  // Clock edges count only while selected and not paused
  assign shift_en  = frame_ff && !cs_n && hold_n;

  // Bit and byte position within the frame
  logic [2:0] bit_cnt_ff;
  logic       byte_seen_ff;
  logic       first_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_ff   <= `ESP_BIT_FIRST;
      byte_seen_ff <= 1'b0;
      first_ff     <= 1'b1;
    end else if (i_ce) begin
      if (!frame_ff) begin
        bit_cnt_ff   <= `ESP_BIT_FIRST;
        byte_seen_ff <= 1'b0;
        first_ff     <= 1'b1;
      end else if (shift_en && sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == `ESP_BIT_LAST) begin
          byte_seen_ff <= 1'b1;
          first_ff     <= 1'b0;
        end
      end
    end
  end

  // Input shift register, sampled on the rising clock edge
  logic [`ESP_BYTE_BITS-1:0] rx_shift_ff;
  logic [`ESP_BYTE_BITS-1:0] nxt_rx_byte;
  logic                      rx_push;

  assign nxt_rx_byte = {rx_shift_ff[`ESP_BYTE_BITS-2:0], si_sync_ff[1]};
  assign rx_push     = shift_en && sck_rise && (bit_cnt_ff == `ESP_BIT_LAST);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_shift_ff <= '0;
    end else if (i_ce && shift_en && sck_rise) begin
      rx_shift_ff <= nxt_rx_byte;
    end
  end

  // Receive FIFO; the master cannot be stalled, so a full FIFO drops the byte
  esp_rx_t fifo_in;
  logic    fifo_ready;

  assign fifo_in.first = first_ff;
  assign fifo_in.data  = nxt_rx_byte;

  esp_fifo #(
    .WIDTH ($bits(esp_rx_t)),
    .DEPTH (`ESP_FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_wr_data  (fifo_in),
    .i_wr_valid (rx_push),
    .o_wr_ready (fifo_ready),
    .o_rd_data  (o_rx),
    .o_rd_valid (o_rx_valid),
    .i_rd_ready (i_rx_ready)
  );

  // Overrun is sticky until the next frame opens; a loss in that cycle still sets it
  logic overrun_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_ff <= 1'b0;
    end else if (i_ce) begin
      if (rx_push && !fifo_ready) begin
        overrun_ff <= 1'b1;
      end else if (!frame_ff && !cs_n) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  assign o_rx_overrun = overrun_ff;

  // Output shifter, moves after the falling clock edge
  logic [`ESP_BYTE_BITS-1:0] tx_shift_ff;
  logic                      so_ff;
  logic                      tx_take_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_shift_ff <= '0;
      so_ff       <= 1'b0;
      tx_take_ff  <= 1'b0;
    end else if (i_ce) begin
      tx_take_ff <= 1'b0;
      if (shift_en && sck_fall) begin
        if (bit_cnt_ff == `ESP_BIT_FIRST) begin
          so_ff       <= i_tx_data[`ESP_BYTE_BITS-1];
          tx_shift_ff <= {i_tx_data[`ESP_BYTE_BITS-2:0], 1'b0};
          tx_take_ff  <= 1'b1;
        end else begin
          so_ff       <= tx_shift_ff[`ESP_BYTE_BITS-1];
          tx_shift_ff <= {tx_shift_ff[`ESP_BYTE_BITS-2:0], 1'b0};
        end
      end
    end
  end

  assign o_so      = so_ff;
  assign o_tx_take = tx_take_ff;
  // Released when deselected or paused, so others can share the line
  assign o_so_oe   = frame_ff && !cs_n && hold_n;

  // End-of-frame decision: start a write, refuse a status write, or abandon
  esp_state_t state_ff;
  logic       seq_valid;
  logic       protect_hit;
  logic       start_write;

  // A write counts only when select rises on a byte boundary after whole data
  assign seq_valid   = i_write_ok && byte_seen_ff && (bit_cnt_ff == `ESP_BIT_FIRST);
  // The pin is looked at only when the enable bit is set
  assign protect_hit = i_sr_write && i_protect_pin_enable && !wp_n;
  assign start_write = frame_end && seq_valid && !protect_hit && (state_ff != ESP_WRITING);

  // Select state machine
  logic [TW-1:0] wc_cnt_ff;
  logic          wc_done;

  assign wc_done = (state_ff == ESP_WRITING) && (wc_cnt_ff == TW'(TWC_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ESP_STANDBY;
    end else if (i_ce) begin
      case (state_ff)
        ESP_STANDBY: begin
          if (!cs_n) begin
            state_ff <= ESP_ACTIVE;
          end
        end
        ESP_ACTIVE: begin
          if (start_write) begin
            state_ff <= ESP_WRITING;
          end else if (cs_n) begin
            state_ff <= ESP_STANDBY;
          end
        end
        ESP_WRITING: begin
          // Select has no say until the cycle is over
          if (wc_done) begin
            state_ff <= cs_n ? ESP_STANDBY : ESP_ACTIVE;
          end
        end
        default: begin
          state_ff <= ESP_STANDBY;
        end
      endcase
    end
  end

  // Self-timed write counter; the protect pin is not an input here at all
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wc_cnt_ff <= '0;
    end else if (i_ce) begin
      if (start_write || state_ff != ESP_WRITING) begin
        wc_cnt_ff <= '0;
      end else begin
        wc_cnt_ff <= wc_cnt_ff + TW'(1);
      end
    end
  end

  // Event pulses, one clock each
  logic write_start_ff;
  logic sr_blocked_ff;
  logic abort_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      write_start_ff <= 1'b0;
      sr_blocked_ff  <= 1'b0;
      abort_ff       <= 1'b0;
    end else if (i_ce) begin
      write_start_ff <= start_write;
      sr_blocked_ff  <= frame_end && seq_valid && protect_hit;
      abort_ff       <= frame_end && !seq_valid && (bit_cnt_ff != `ESP_BIT_FIRST);
    end
  end

  assign o_write_start = write_start_ff;
  assign o_sr_blocked  = sr_blocked_ff;
  assign o_frame_abort = abort_ff;
  assign o_write_busy  = (state_ff == ESP_WRITING);
  assign o_standby     = (state_ff == ESP_STANDBY);

endmodule

/* File: hdl/esp_regs.svh */
// Constants for the serial EEPROM select and protect front end.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ESP_REGS_SVH
`define ESP_REGS_SVH

`define ESP_CLK_KHZ    125000      // System clock rate in kHz
`define ESP_TWC_MS     5           // Longest internal write cycle, ms
`define ESP_BYTE_BITS  8           // Bits in one serial byte
`define ESP_BIT_LAST   3'h7        // Index of the last bit of a byte
`define ESP_BIT_FIRST  3'h0        // Bit counter at a byte boundary
`define ESP_PIN_IDLE   2'h3        // Synchroniser reset value, pins idle high
`define ESP_FIFO_DEPTH 8           // Receive FIFO depth in bytes

`endif

/* File: hdl/esp_pkg.sv */
// Types shared by the serial EEPROM front end and its receive FIFO.
// Assumes esp_regs.svh sits on the include path.
`include "esp_regs.svh"

package esp_pkg;

  // Byte received from the serial input
  typedef struct packed {
    logic                      first; // First byte after select
    logic [`ESP_BYTE_BITS-1:0] data;  // Byte, MSB received first
  } esp_rx_t;

  // Select state, Gray coded along standby, active, writing
  typedef enum logic [1:0] {
    ESP_STANDBY = 2'b00,
    ESP_ACTIVE  = 2'b01,
    ESP_WRITING = 2'b11
  } esp_state_t;

endpackage

/* File: hdl/esp_fifo.sv */
// Small shift-register FIFO; the head entry is a register, so read data is registered.
// Assumes one clock, a clock enable and an asynchronous active-high reset.
`timescale 1ns/100ps
`include "esp_regs.svh"

module esp_fifo #(
  parameter int WIDTH = 9,                  // Word width
  parameter int DEPTH = `ESP_FIFO_DEPTH     // Entries
) (
  input  wire logic             i_clk,      // Clock
  input  wire logic             i_rst,      // Async reset, active high
  input  wire logic             i_ce,       // Clock enable
  input  wire logic [WIDTH-1:0] i_wr_data,  // Write word
  input  wire logic             i_wr_valid, // Write request
  output logic                  o_wr_ready, // Room for a word
  output logic      [WIDTH-1:0] o_rd_data,  // Head word
  output logic                  o_rd_valid, // Head word present
  input  wire logic             i_rd_ready  // Reader takes head
);

  localparam int CW = $clog2(DEPTH + 1);

  // Elaboration check: the shift scheme needs at least two entries
  if (DEPTH < 2 || WIDTH < 1) begin : g_param_check
    $error("esp_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CW-1:0]    count_ff;
  logic             push;
  logic             pop;

  // Full and empty come straight from the count
  assign o_wr_ready = (count_ff != CW'(DEPTH));
  assign o_rd_valid = (count_ff != '0);
  assign o_rd_data  = mem_ff[0];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;

  // Occupancy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_ff <= '0;
    end else if (i_ce) begin
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

  // Each entry shifts toward the head on pop and takes the new word at the tail
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        mem_ff[g] <= '0;
      end else if (i_ce) begin
        if (push && (CW'(g) == count_ff - CW'(pop))) begin
          mem_ff[g] <= i_wr_data;
        end else if (pop) begin
          mem_ff[g] <= (g == DEPTH - 1) ? mem_ff[g] : mem_ff[(g + 1) % DEPTH];
        end
      end
    end
  end

endmodule

/* File: tb/esp_front_assertions.sv */
// Checker for the select, write-cycle and protect front end; pins reach logic two flops late.
// Assumes it is bound to esp_front, sees only its ports and runs with the clock enable held high.
`timescale 1ns/100ps

module esp_front_assertions #(
  parameter int TWC_CYCLES = 40 // Write cycle length, clocks
) (
  input wire logic i_clk,                // System clock
  input wire logic i_rst,                // Async reset, active high
  input wire logic i_cs_n,               // Chip select pin
  input wire logic i_hold_n,             // Pause pin
  input wire logic i_wp_n,               // Write-protect pin
  input wire logic i_protect_pin_enable, // Protect pin enable bit
  input wire logic o_so_oe,              // Output enable
  input wire logic o_write_start,        // Write start pulse
  input wire logic o_write_busy,         // Write in progress
  input wire logic o_sr_blocked,         // Status write refused
  input wire logic o_frame_abort,        // Sequence abandoned
  input wire logic o_standby             // Standby
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [31:0] busy_ff; // Busy cycles of the running write
  // Cleared while idle so that each write cycle is measured on its own
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) busy_ff <= 32'h0;
    else       busy_ff <= o_write_busy ? busy_ff + 32'h1 : 32'h0;
  end

  AST_OE_DESEL: assert property (i_cs_n [*3] |-> !o_so_oe) else $error("output driven while deselected");
  AST_OE_PAUSE: assert property (!i_hold_n [*3] |-> !o_so_oe) else $error("output driven while paused");
  AST_BUSY_CAUSE: assert property ($rose(o_write_busy) |-> o_write_start) else $error("busy without start");
  AST_BUSY_LEN: assert property ($fell(o_write_busy) |-> busy_ff == TWC_CYCLES) else $error("busy length off");
  AST_NO_RESTART: assert property ($past(o_write_busy) |-> !o_write_start) else $error("restart while busy");
  AST_BUSY_STBY: assert property (o_write_busy |-> !o_standby) else $error("standby during write");
  AST_DESEL_STBY: assert property (i_cs_n [*5] ##0 !o_write_busy |-> o_standby) else $error("no standby");
  AST_SEL_ACTIVE: assert property (!i_cs_n [*5] |-> !o_standby) else $error("standby while selected");
  AST_BLOCK_CAUSE: assert property (o_sr_blocked |-> !$past(i_wp_n, 3) && $past(i_protect_pin_enable))
    else $error("refusal without cause");
  AST_BLOCK_QUIET: assert property (o_sr_blocked |-> !o_write_start [*3]) else $error("start after refusal");
  AST_ABORT_CS: assert property (o_frame_abort |-> $past(i_cs_n, 3)) else $error("abort while selected");

  CV_START: cover property (o_write_start);
  CV_BLOCK: cover property (o_sr_blocked);
  CV_ABORT: cover property (o_frame_abort);
endmodule

/* File: tb/esp_master_model.sv */
// Behavioural SPI master in mode 0, MSB first, with a 64 ns serial clock.
// Assumes the device updates its output within the low phase; samples it late in the high phase.
`timescale 1ns/100ps

module esp_master_model (
  output logic o_cs_n,   // Chip select, active low
  output logic o_sck,    // Serial clock, idle low
  output logic o_si,     // Serial data to device
  output logic o_hold_n, // Pause, active low
  input  wire  i_so      // Serial data from device
);
  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
  end

  // Select, then leave the device time to open its frame before the first edge
  task automatic sel();
    o_cs_n = 1'b0;
    #64;
  endtask

  // Raise select right after the last falling edge; data line stops holding its value
  task automatic desel();
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    #64;
  endtask

  task automatic pause(input logic v);
    o_hold_n = v;
  endtask

  // Shift nb bits of d out, collecting the device's bits in q
  task automatic xfer(input logic [7:0] d, input int nb, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      o_si  = d[i];
      #32 o_sck = 1'b1;
      #30 q[i] = i_so;
      #2 o_sck = 1'b0;
    end
  endtask
endmodule

/* File: tb/esp_front_bench.sv */
// Self-checking bench for esp_front with a behavioural SPI master on its pins.
// Assumes a shortened write cycle of 100 clocks and the clock enable held high.
`timescale 1ns/100ps

module esp_front_bench;
  import esp_pkg::*;
  // Long enough that a second whole-byte frame ends inside the running write
  localparam int TWC = 100;
  logic clk, rst, cs_n, sck, si, hold_n, wp_n, so, so_oe, rx_valid, rdy, overrun, take;
  logic wr_ok, sr_wr, pen, start, busy, blocked, abort, standby;
  logic [7:0] tx, q;
  esp_rx_t rx;
  int n_errors, n_checks, n_start, n_block, n_abort, n_busy, n_take;

  esp_front #(.TWC_CYCLES(TWC)) dut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_rx(rx), .o_rx_valid(rx_valid),
    .i_rx_ready(rdy), .o_rx_overrun(overrun), .i_tx_data(tx), .o_tx_take(take), .i_write_ok(wr_ok),
    .i_sr_write(sr_wr), .i_protect_pin_enable(pen), .o_write_start(start), .o_write_busy(busy),
    .o_sr_blocked(blocked), .o_frame_abort(abort), .o_standby(standby));
  esp_master_model m (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n), .i_so(so_oe ? so : ~so));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulse and busy tallies, so no one-cycle pulse is missed between checks
  // Sampled on the falling edge, where registered outputs have settled
  always @(negedge clk) begin
    if (take === 1'b1) n_take++;
    if (start === 1'b1) n_start++;
    if (blocked === 1'b1) n_block++;
    if (abort === 1'b1) n_abort++;
    if (busy === 1'b1) n_busy++;
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the write cycle to end
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) clks(1);
    chk(busy === 1'b0, "write cycle never ended");
  endtask

  task automatic clear();
    n_start = 0; n_block = 0; n_abort = 0; n_busy = 0; n_take = 0;
  endtask

  // Deselected clock traffic, then nine bytes into a stalled buffer of eight
  task automatic t_fifo();
    rdy = 1'b0;
    m.xfer(8'hFF, 8, q);
    clks(6);
    chk(rx_valid === 1'b0, "byte taken while deselected");
    m.sel();
    for (int i = 0; i < 9; i++) m.xfer(8'(i + 8'h30), 8, q);
    m.desel();
    chk(overrun === 1'b1, "no overrun");
    for (int i = 0; i < 8; i++) begin
      chk(rx_valid === 1'b1 && rx.data === 8'(i + 8'h30) && rx.first === (i == 0), "rx byte");
      rdy = 1'b1;
      clks(1);
      rdy = 1'b0;
      clks(1);
    end
    chk(rx_valid === 1'b0, "buffer not empty");
    $display("test fifo done");
  endtask

  // Second byte returns the core's byte after the first byte boundary
  task automatic t_read();
    rdy = 1'b1;
    tx  = 8'hA5;
    clear();
    m.sel();
    chk(so_oe === 1'b1, "output not driven when selected");
    chk(overrun === 1'b0, "overrun kept into new frame");
    m.xfer(8'h03, 8, q);
    m.xfer(8'h00, 8, q);
    chk(q === 8'hA5, "read byte");
    chk(n_take == 1, "tx byte loads");
    m.pause(1'b0);
    clks(4);
    chk(so_oe === 1'b0, "output driven while paused");
    m.pause(1'b1);
    m.desel();
    chk(so_oe === 1'b0 && standby === 1'b1, "deselect");
    $display("test read done");
  endtask

  // Frame of one armed write, WP dropped and a second write frame offered while busy
  task automatic t_write();
    logic sb;
    clear();
    wr_ok = 1'b1;
    m.sel();
    m.xfer(8'h02, 8, q);
    m.desel();
    wp_n = 1'b0;
    m.sel();
    m.xfer(8'h02, 8, q);
    sb = standby;
    m.desel();
    wr_ok = 1'b0;
    chk(busy === 1'b1 && standby === 1'b0, "write not running");
    wait_idle();
    clks(2);
    chk(n_start == 1 && n_busy == TWC, "write cycle count");
    chk(sb === 1'b0 && standby === 1'b1, "standby after write");
    wp_n = 1'b1;
    $display("test write done");
  endtask

  // Status write with the protect pin low, enable bit clear then set
  task automatic t_protect();
    wp_n  = 1'b0;
    sr_wr = 1'b1;
    for (int en = 0; en < 2; en++) begin
      clear();
      pen   = en[0];
      wr_ok = 1'b1;
      m.sel();
      m.xfer(8'h01, 8, q);
      m.xfer(8'h80, 8, q);
      m.desel();
      wr_ok = 1'b0;
      chk(n_block == en && n_start == 1 - en, "protect gating");
      wait_idle();
    end
    wp_n = 1'b1; sr_wr = 1'b0; pen = 1'b0;
    $display("test protect done");
  endtask

  // Select dropped mid-byte abandons the armed write
  task automatic t_abort();
    clear();
    wr_ok = 1'b1;
    m.sel();
    m.xfer(8'h02, 8, q);
    m.xfer(8'hC0, 4, q);
    m.desel();
    wr_ok = 1'b0;
    chk(n_abort == 1 && n_start == 0 && busy === 1'b0, "abort");
    $display("test abort done");
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1; wp_n = 1'b1; rdy = 1'b0; tx = 8'h00; wr_ok = 1'b0; sr_wr = 1'b0; pen = 1'b0;
    n_errors = 0; n_checks = 0;
    clear();
    clks(4);
    rst = 1'b0;
    clks(2);
    chk(standby === 1'b1 && so_oe === 1'b0 && busy === 1'b0, "reset state");
    t_fifo();
    t_read();
    t_write();
    t_protect();
    t_abort();
    conclude();
  end

  // Watchdog well beyond the roughly 12 us the tests take
  initial begin
    #300000;
    n_errors++;
    $display("wrong value at %0t: watchdog", $time);
    conclude();
  end
endmodule

bind esp_front esp_front_assertions #(.TWC_CYCLES(TWC_CYCLES)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .i_protect_pin_enable(i_protect_pin_enable),
  .o_so_oe(o_so_oe), .o_write_start(o_write_start), .o_write_busy(o_write_busy), .o_sr_blocked(o_sr_blocked),
  .o_frame_abort(o_frame_abort), .o_standby(o_standby));
